/* File: rtl/rwt_pkg.sv */
// constants, types and register map of the reset, watchdog and tick unit
package rwt_pkg;

	// ==========================================================
	// timing
	localparam int          CLK_PERIOD_NS = 10;
	// reset sequence lengths in pll_output_clock cycles
	localparam logic [9:0]  RG_PIN_LOW    = 10'h200;
	localparam logic [9:0]  RG_SEQ_LEN    = 10'h300;
	// a monitored clock without an edge for this long counts as failed
	localparam int          MON_GAP_NS    = 2000;
	localparam int          MON_GAP_CYC   = MON_GAP_NS / CLK_PERIOD_NS;
	localparam int          MON_W         = 8;

	// ==========================================================
	// register indices (byte address = 4 * index)
	localparam logic [2:0]  IDX_WD_CTRL   = 3'h0;
	localparam logic [2:0]  IDX_WD_SVC    = 3'h1;
	localparam logic [2:0]  IDX_TICK_RATE = 3'h2;
	localparam logic [2:0]  IDX_TICK_CTRL = 3'h3;
	localparam logic [2:0]  IDX_CLK_CTRL  = 3'h4;
	localparam logic [2:0]  IDX_STATUS    = 3'h5;
	localparam int          ADDR_W        = 5;
	localparam int          IDX_LSB       = 2;

	// ==========================================================
	// field positions
	localparam int          WD_PERIOD_LSB = 0;
	localparam int          WD_PERIOD_W   = 3;
	localparam int          WD_MASK_BIT   = 6;
	localparam int          WD_WINDOW_BIT = 7;
	localparam int          CK_OSC_EN_BIT = 0;
	localparam int          CK_CRYSTAL_MONITOR_RESET_ENABLE_BIT   = 1;
	localparam int          CK_PSEUDO_STOP_SELECT_BIT   = 2;
	localparam int          CK_KEEP_BIT   = 3;
	localparam int          CK_SEL_LO_BIT = 4;
	localparam int          CK_SEL_HI_BIT = 5;
	localparam int          CK_RCSD_BIT   = 6;
	localparam int          TK_SEL_BIT    = 0;
	localparam int          TK_IE_BIT     = 1;
	localparam int          TK_FLAG_BIT   = 2;
	localparam int          TK_MOD_LSB    = 0;
	localparam int          TK_MOD_W      = 4;
	localparam int          TK_PRE_LSB    = 4;
	localparam int          TK_PRE_W      = 3;
	localparam int          ST_CAUSE_LSB  = 0;
	localparam int          ST_WRITTEN    = 4;
	localparam int          ST_XTAL_UP    = 5;
	// reset cause vector order
	localparam int          CAUSE_WD      = 0;
	localparam int          CAUSE_PLL     = 1;
	localparam int          CAUSE_OSC     = 2;
	localparam int          CAUSE_EXT     = 3;

	// ==========================================================
	// watchdog and tick
	localparam logic [7:0]  SVC_KEY_A     = 8'h55;
	localparam logic [7:0]  SVC_KEY_B     = 8'haa;
	localparam logic [2:0]  WD_OFF        = 3'h0;
	localparam int          WD_CNT_W      = 24;
	localparam logic [23:0] WD_ONE        = 24'h000001;
	localparam int          WD_LIM_BASE   = 4;
	localparam int          WD_LIM_STEP   = 2;
	localparam int          TICK_CNT_W    = 16;
	localparam logic [15:0] TICK_ONE      = 16'h0001;
	localparam logic [7:0]  TICK_OFF      = 8'h00;

	// sampled input order
	localparam int          CK_PLL        = 0;
	localparam int          CK_IRC        = 1;
	localparam int          CK_XTAL       = 2;
	localparam int          CK_RC         = 3;
	localparam int          CK_PIN        = 4;
	localparam int          NUM_SAMP      = 5;

	typedef enum logic [2:0] {
		RWT_RG_IDLE = 3'b001,
		RWT_RG_PULL = 3'b010,
		RWT_RG_HOLD = 3'b100
	} rwt_rg_state_t;

	typedef struct packed {
		logic              read;
		logic              write;
		logic [ADDR_W-1:0] address;
		logic [31:0]       writedata;
	} rwt_avs_req_t;

	typedef struct packed {
		logic [31:0] readdata;
		logic        waitrequest;
	} rwt_avs_rsp_t;

endpackage

/* File: rtl/rwt_sampler.sv */
// two-flop synchroniser with rising-edge pulse for one outside signal
`timescale 1ns/1ps
`default_nettype none
module rwt_sampler (
	// clock and reset
	input  wire logic clk,
	input  wire logic srst,
	// outside signal
	input  wire logic din,
	// synchronised level and one-cycle rising-edge pulse
	output logic      level,
	output logic      rise
);
	import rwt_pkg::*;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic rise;
	} rwt_samp_t;

	rwt_samp_t q;
	rwt_samp_t next_q;

	always_comb begin
		next_q      = q;
		next_q.s1   = din;
		next_q.s2   = q.s1;
		next_q.s3   = q.s2;
		next_q.rise = q.s2 & ~q.s3;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign level = q.s2;
	assign rise  = q.rise;
endmodule
`default_nettype wire

/* File: rtl/rwt_unit.sv */
// reset generator, clock monitors, program watchdog and periodic tick timer
//
// Functional notes
// R1: internal reset source drives reset pin low 512 pll cycles, then releases it
// R2: internal reset held until the 768 pll cycle sequence completes
// R3: reset pin held low outside beyond 768 cycles extends internal reset
// R4: crystal enabled with monitor reset enabled: lost crystal clock raises reset
// R5: full stop disables crystal, its monitor, the pll and its monitor
// R6: lost or too slow pll clock raises a pll monitor reset
// R7: watchdog counts rc, internal reference or crystal clock per two select bits
// R8: rc clock stop entry and exit each synchronised over 2 rc cycles
// R9: software waits 2 rc cycles after stop exit before the next stop
// R10: in stop watchdog runs only on allowed rc or crystal setups, else static
// R11: three-bit period field picks seven timeouts, zero turns watchdog off
// R12: writing 0x55 then 0xaa to service register restarts the timeout
// R13: timeout without completed service raises a watchdog reset
// R14: any service value other than 0x55 or 0xaa resets at once
// R15: window mode: service before final quarter of period resets at once
// R16: normal mode preloads period and window at reset release, else off
// R17: normal mode: control register takes one update; off refused when preload enabled it
// R18: watchdog clock select is not preloaded, defaults to internal reference
// R19: clock select and rc stop disable writable only until the single update
// R20: control write with mask bit set changes nothing and is not counted
// R21: tick clock from reference or crystal; in stop runs only in kept setup
// R22: tick end sets flag, raises enabled request, restarts; rate write restarts
// R23: period and tick rate cycle counts are chosen by this design
`timescale 1ns/1ps
`default_nettype none
module rwt_unit (
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 srst,
	// register bus
	input  wire rwt_pkg::rwt_avs_req_t avs_req,
	output rwt_pkg::rwt_avs_rsp_t     avs_rsp,
	// clocks sampled from outside
	input  wire logic                 pll_output_clock,
	input  wire logic                 internal_ref_clock,
	input  wire logic                 crystal_clock,
	input  wire logic                 rc_clock,
	// open-drain reset pin
	input  wire logic                 rst_pin_in,
	output logic                      rst_pin_out,
	output logic                      rst_pin_oe,
	// core status
	input  wire logic                 stop_mode,
	input  wire logic                 normal_mode,
	input  wire logic                 crystal_up_status,
	// non-volatile preload values
	input  wire logic                 nvm_valid,
	input  wire logic [2:0]           nvm_period,
	input  wire logic                 nvm_window,
	// outputs to the system
	output logic                      sys_reset,
	output logic                      crystal_run,
	output logic                      pll_run,
	output logic                      tick_irq
);
	import rwt_pkg::*;

	// ==========================================================
	// state
	typedef struct packed {
		rwt_rg_state_t           rg_state;
		logic [9:0]              rg_cnt;
		logic                    pin_oe;
		logic                    pin_out;
		logic                    sys_reset;
		logic [3:0]              cause;
		logic                    osc_en;
		logic                    crystal_monitor_reset_enable;
		logic                    pseudo_stop_select;
		logic                    keep;
		logic                    sel_lo;
		logic                    sel_hi;
		logic                    rc_stop_dis;
		logic [2:0]              wd_period;
		logic                    wd_window;
		logic                    wd_written;
		logic                    wd_preload_on;
		logic                    wd_armed;
		logic [WD_CNT_W-1:0]     wd_cnt;
		logic                    wd_fire;
		logic [1:0]              stop_rc;
		logic                    tick_sel;
		logic                    tick_ie;
		logic                    tick_flag;
		logic [7:0]              tick_rate;
		logic [TICK_CNT_W-1:0]   tick_cnt;
		logic                    tick_irq;
		logic [MON_W-1:0]        pll_mon;
		logic [MON_W-1:0]        osc_mon;
		logic                    xtal_run;
		logic                    pll_run;
		logic                    waitreq;
		logic [31:0]             rdata;
	} rwt_state_t;

	// starts in the pull phase so that the first release loads the preload
	localparam rwt_state_t RESET_STATE = '{
		rg_state: RWT_RG_PULL, pin_oe: 1'b1, sys_reset: 1'b1, waitreq: 1'b1,
		pll_run: 1'b1, default: '0};

	rwt_state_t q;
	rwt_state_t next_q;

	// ==========================================================
	// helpers
	function automatic logic [2:0] reg_index(input logic [ADDR_W-1:0] a);
		reg_index = a[IDX_LSB +: 3];
	endfunction

	function automatic logic [WD_CNT_W-1:0] wd_limit(input logic [2:0] code);
		wd_limit = WD_ONE << (int'(code) * WD_LIM_STEP + WD_LIM_BASE); // R23
	endfunction

	function automatic logic [TICK_CNT_W-1:0] tick_limit(input logic [7:0] r);
		tick_limit = ({12'h000, r[TK_MOD_LSB +: TK_MOD_W]} + TICK_ONE) // R23
			<< r[TK_PRE_LSB +: TK_PRE_W];
	endfunction

	// ==========================================================
	// outside clocks and pin through two flops each
	logic [NUM_SAMP-1:0] raw;
	logic [NUM_SAMP-1:0] lvl;
	logic [NUM_SAMP-1:0] rise;

	assign raw = {rst_pin_in, rc_clock, crystal_clock, internal_ref_clock, pll_output_clock};

	for (genvar g = 0; g < NUM_SAMP; g++) begin : g_samp
		rwt_sampler u_samp (
			.clk   (clk),
			.srst  (srst),
			.din   (raw[g]),
			.level (lvl[g]),
			.rise  (rise[g])
		);
	end

	// ==========================================================
	// decoded terms shared by logic and checks
	logic                acc_wr;
	logic [2:0]          idx;
	logic                full_stop;
	logic                wd_on;
	logic                wd_tick;
	logic                tick_tick;
	logic [WD_CNT_W-1:0] lim;
	logic [WD_CNT_W-1:0] thr;
	logic                pll_fail;
	logic                osc_fail;
	logic [3:0]          src;

	assign acc_wr    = avs_req.write && !q.waitreq;
	assign idx       = reg_index(avs_req.address);
	assign full_stop = stop_mode && !q.pseudo_stop_select;
	assign wd_on     = (q.wd_period != WD_OFF) && !q.sys_reset;
	assign lim       = wd_limit(q.wd_period);
	assign thr       = lim - (lim >> 2); // R15
	assign pll_fail  = q.pll_mon == MON_W'(MON_GAP_CYC); // R6
	assign osc_fail  = q.osc_mon == MON_W'(MON_GAP_CYC); // R4
	assign src[CAUSE_WD]  = q.wd_fire;
	assign src[CAUSE_PLL] = pll_fail;
	assign src[CAUSE_OSC] = osc_fail;
	assign src[CAUSE_EXT] = !lvl[CK_PIN] && !q.pin_oe;

	always_comb begin
		if (q.sel_hi) begin
			// rc path sees stop only after two rc edges each way
			wd_tick = rise[CK_RC] && !(q.stop_rc[1] && q.rc_stop_dis); // R7 R8 R10
		end else if (q.sel_lo) begin
			wd_tick = rise[CK_XTAL] && (!stop_mode ||
				(q.pseudo_stop_select && q.keep && q.osc_en && crystal_up_status)); // R7 R10
		end else begin
			wd_tick = rise[CK_IRC] && !stop_mode; // R7 R10
		end
	end

	assign tick_tick = (q.tick_sel ? rise[CK_XTAL] : rise[CK_IRC]) &&
		(!stop_mode || (q.pseudo_stop_select && q.tick_sel && q.keep)); // R21

	// ==========================================================
	// next state
	always_comb begin
		next_q         = q;
		next_q.wd_fire = 1'b0;

		// clock gating and monitors
		next_q.xtal_run = q.osc_en && !full_stop; // R5
		next_q.pll_run  = !full_stop; // R5
		if (full_stop || rise[CK_PLL]) begin
			next_q.pll_mon = '0;
		end else if (!pll_fail) begin
			next_q.pll_mon = q.pll_mon + MON_W'(1); // R6
		end
		if (!(q.osc_en && q.crystal_monitor_reset_enable) || full_stop || rise[CK_XTAL]) begin
			next_q.osc_mon = '0; // R5
		end else if (!osc_fail) begin
			next_q.osc_mon = q.osc_mon + MON_W'(1); // R4
		end
		if (rise[CK_RC]) begin
			next_q.stop_rc = {q.stop_rc[0], stop_mode}; // R8
		end

		// watchdog counter
		if (wd_on && wd_tick) begin
			if (q.wd_cnt == lim - WD_ONE) begin
				next_q.wd_fire = 1'b1; // R13
				next_q.wd_cnt  = '0;
			end else begin
				next_q.wd_cnt = q.wd_cnt + WD_ONE; // R11
			end
		end

		// bus slave: one wait cycle, then the access completes
		next_q.waitreq = 1'b1;
		if ((avs_req.read || avs_req.write) && q.waitreq) begin
			next_q.waitreq = 1'b0;
			case (idx)
				IDX_WD_CTRL:   next_q.rdata = {24'h000000, q.wd_window, 4'h0, q.wd_period};
				IDX_TICK_RATE: next_q.rdata = {24'h000000, q.tick_rate};
				IDX_TICK_CTRL: next_q.rdata = {29'h00000000, q.tick_flag, q.tick_ie, q.tick_sel};
				IDX_CLK_CTRL:  next_q.rdata = {25'h0000000, q.rc_stop_dis, q.sel_hi,
					q.sel_lo, q.keep, q.pseudo_stop_select, q.crystal_monitor_reset_enable, q.osc_en};
				IDX_STATUS:    next_q.rdata = {26'h0000000, crystal_up_status,
					q.wd_written, q.cause};
				default:       next_q.rdata = 32'h00000000;
			endcase
		end
		if (acc_wr) begin
			case (idx)
				IDX_WD_CTRL: begin
					if (!avs_req.writedata[WD_MASK_BIT] &&
						!(normal_mode && q.wd_written)) begin // R17 R20
						if (!(normal_mode && q.wd_preload_on && avs_req.writedata
							[WD_PERIOD_LSB +: WD_PERIOD_W] == WD_OFF)) begin // R17
							next_q.wd_period = avs_req.writedata[WD_PERIOD_LSB +: WD_PERIOD_W];
							next_q.wd_window = avs_req.writedata[WD_WINDOW_BIT];
						end
						next_q.wd_written = normal_mode;
					end
				end
				IDX_WD_SVC: begin
					if (wd_on) begin
						if (q.wd_window && q.wd_cnt < thr) begin
							next_q.wd_fire = 1'b1; // R15
						end else if (avs_req.writedata[7:0] == SVC_KEY_A) begin
							next_q.wd_armed = 1'b1;
						end else if (avs_req.writedata[7:0] == SVC_KEY_B) begin
							if (q.wd_armed) begin
								next_q.wd_cnt   = '0; // R12
								next_q.wd_armed = 1'b0;
							end
						end else begin
							next_q.wd_fire = 1'b1; // R14
						end
					end
				end
				IDX_TICK_RATE: begin
					next_q.tick_rate = avs_req.writedata[7:0];
					next_q.tick_cnt  = '0; // R22
				end
				IDX_TICK_CTRL: begin
					next_q.tick_sel = avs_req.writedata[TK_SEL_BIT];
					next_q.tick_ie  = avs_req.writedata[TK_IE_BIT];
					if (avs_req.writedata[TK_FLAG_BIT]) begin
						next_q.tick_flag = 1'b0;
					end
				end
				IDX_CLK_CTRL: begin
					next_q.osc_en = avs_req.writedata[CK_OSC_EN_BIT];
					next_q.crystal_monitor_reset_enable   = avs_req.writedata[CK_CRYSTAL_MONITOR_RESET_ENABLE_BIT];
					next_q.pseudo_stop_select   = avs_req.writedata[CK_PSEUDO_STOP_SELECT_BIT];
					next_q.keep   = avs_req.writedata[CK_KEEP_BIT];
					if (!q.wd_written) begin
						next_q.sel_lo      = avs_req.writedata[CK_SEL_LO_BIT]; // R19
						next_q.sel_hi      = avs_req.writedata[CK_SEL_HI_BIT];
						next_q.rc_stop_dis = avs_req.writedata[CK_RCSD_BIT];
					end
				end
				IDX_STATUS: begin
					next_q.cause = q.cause & ~avs_req.writedata[ST_CAUSE_LSB +: 4];
				end
				default: begin
				end
			endcase
		end

		// tick timer; a rate write in the same cycle wins over the count
		if (q.tick_rate != TICK_OFF && tick_tick && !(acc_wr && idx == IDX_TICK_RATE)) begin
			if (q.tick_cnt == tick_limit(q.tick_rate) - TICK_ONE) begin
				next_q.tick_cnt  = '0; // R22
				next_q.tick_flag = 1'b1; // R22
			end else begin
				next_q.tick_cnt = q.tick_cnt + TICK_ONE;
			end
		end
		next_q.tick_irq = next_q.tick_flag && next_q.tick_ie; // R22

		// reset generator
		case (q.rg_state)
			RWT_RG_IDLE: begin
				if (|src) begin
					next_q.rg_state  = RWT_RG_PULL;
					next_q.rg_cnt    = '0;
					next_q.pin_oe    = 1'b1; // R1
					next_q.sys_reset = 1'b1; // R2
					next_q.cause     = next_q.cause | src;
				end
			end
			RWT_RG_PULL: begin
				if (rise[CK_PLL]) begin
					next_q.rg_cnt = q.rg_cnt + 10'h001;
					if (q.rg_cnt == RG_PIN_LOW - 10'h001) begin
						next_q.pin_oe   = 1'b0; // R1
						next_q.rg_state = RWT_RG_HOLD;
					end
				end
			end
			RWT_RG_HOLD: begin
				if (q.rg_cnt != RG_SEQ_LEN) begin
					if (rise[CK_PLL]) begin
						next_q.rg_cnt = q.rg_cnt + 10'h001; // R2
					end
				end else if (lvl[CK_PIN]) begin // R3
					next_q.rg_state      = RWT_RG_IDLE;
					next_q.sys_reset     = 1'b0;
					next_q.wd_period     = (normal_mode && nvm_valid) ? nvm_period : WD_OFF; // R16
					next_q.wd_window     = normal_mode && nvm_valid && nvm_window; // R16
					next_q.wd_preload_on = normal_mode && nvm_valid && nvm_period != WD_OFF;
					next_q.wd_written    = 1'b0;
					next_q.wd_armed      = 1'b0;
					next_q.wd_cnt        = '0;
					next_q.sel_lo        = 1'b0; // R18
					next_q.sel_hi        = 1'b0; // R18
				end
			end
			default: begin
				next_q.rg_state = RWT_RG_PULL;
				next_q.rg_cnt   = '0;
				next_q.pin_oe   = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			q <= RESET_STATE;
		end else begin
			q <= next_q;
		end
	end

	// ==========================================================
	// outputs
	assign avs_rsp.readdata    = q.rdata;
	assign avs_rsp.waitrequest = q.waitreq;
	assign rst_pin_out         = q.pin_out;
	assign rst_pin_oe          = q.pin_oe;
	assign sys_reset           = q.sys_reset;
	assign crystal_run         = q.xtal_run;
	assign pll_run             = q.pll_run;
	assign tick_irq            = q.tick_irq;

	// ==========================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	a_pin_low_len: assert property ($fell(q.pin_oe) |-> q.rg_cnt == RG_PIN_LOW) // R1
		else $error("reset pin released after wrong cycle count");
	a_seq_len: assert property ($fell(q.sys_reset) |-> $past(q.rg_cnt) == RG_SEQ_LEN) // R2
		else $error("internal reset released before sequence end");
	a_ext_extend: assert property ((q.rg_state == RWT_RG_HOLD && !lvl[CK_PIN]) |=> q.sys_reset) // R3
		else $error("internal reset dropped while pin held low");
	a_osc_mon_rst: assert property ((osc_fail && q.rg_state == RWT_RG_IDLE)
		|=> q.rg_state == RWT_RG_PULL && q.cause[CAUSE_OSC]) // R4
		else $error("crystal monitor failure did not start reset");
	a_full_stop_off: assert property (full_stop |=> !q.xtal_run && !q.pll_run && q.osc_mon == '0
		&& q.pll_mon == '0) // R5
		else $error("full stop left crystal or pll running");
	a_pll_mon_rst: assert property ((pll_fail && q.rg_state == RWT_RG_IDLE)
		|=> q.rg_state == RWT_RG_PULL && q.pin_oe) // R6
		else $error("pll monitor failure did not start reset");
	a_wd_stop_static: assert property ((stop_mode && !q.sel_hi && !q.sel_lo && !acc_wr
		&& q.rg_state == RWT_RG_IDLE) |=> $stable(q.wd_cnt)) // R10
		else $error("watchdog moved in stop on reference clock");
	a_bad_key: assert property ((acc_wr && idx == IDX_WD_SVC && wd_on && !q.wd_window
		&& avs_req.writedata[7:0] != SVC_KEY_A && avs_req.writedata[7:0] != SVC_KEY_B)
		|=> q.wd_fire ##1 q.sys_reset) // R14
		else $error("bad service value did not reset");
	a_svc_restart: assert property ((acc_wr && idx == IDX_WD_SVC && wd_on && q.wd_armed
		&& !(q.wd_window && q.wd_cnt < thr) && avs_req.writedata[7:0] == SVC_KEY_B)
		|=> q.wd_cnt == '0 && !q.wd_armed) // R12
		else $error("service sequence did not restart timeout");
	a_early_svc: assert property ((acc_wr && idx == IDX_WD_SVC && wd_on && q.wd_window
		&& q.wd_cnt < thr) |=> q.wd_fire) // R15
		else $error("early windowed service did not reset");
	a_off_refused: assert property ((acc_wr && idx == IDX_WD_CTRL && normal_mode
		&& q.wd_preload_on && q.wd_period != WD_OFF) |=> q.wd_period != WD_OFF) // R17
		else $error("watchdog turned off after enabled preload");
	a_mask_write: assert property ((acc_wr && idx == IDX_WD_CTRL
		&& avs_req.writedata[WD_MASK_BIT] && q.rg_state == RWT_RG_IDLE)
		|=> $stable(q.wd_period) && $stable(q.wd_written)) // R20
		else $error("masked control write took effect");
	a_tick_restart: assert property ((acc_wr && idx == IDX_TICK_RATE) |=> q.tick_cnt == '0) // R22
		else $error("rate write did not restart tick period");

	c_int_reset: cover property ($fell(q.sys_reset) && q.cause[CAUSE_WD]);
	c_ext_hold: cover property (q.rg_state == RWT_RG_HOLD && q.rg_cnt == RG_SEQ_LEN
		&& !lvl[CK_PIN]);
	c_tick_irq: cover property ($rose(q.tick_irq));
	c_svc_ok: cover property (acc_wr && idx == IDX_WD_SVC && q.wd_armed && wd_on);
endmodule
`default_nettype wire

/* File: testbench/rwt_unit_bench.sv */
// self-checking bench for the reset, watchdog and tick unit
`timescale 1ns/1ps
`default_nettype none
module rwt_unit_bench;
	import rwt_pkg::*;
	// ==========================================================
	// stimulus and wiring
	logic         clk = 0, srst = 1, pll_en = 1, xt_en = 1, ext_rst = 1, stop = 0;
	logic         pll = 0, irc = 0, xt = 0, rc = 0;
	logic         nvm_v = 0, nvm_w = 0;
	logic [2:0]   nvm_p = 3'h0;
	rwt_avs_req_t req = '0;
	rwt_avs_rsp_t rsp;
	logic         pin_out, pin_oe, sys_rst, xrun, prun, irq;
	logic [31:0]  q;
	int           num_errors = 0, n_checks = 0, pc = 0, p0, n;
	// open-drain wire with pull-up: low while the unit drives or the outside pulls
	wire logic    pin_in = pin_oe ? pin_out : ext_rst;

	always #5 clk = ~clk;
	always #40 pll = pll_en ? ~pll : pll;
	always #40 irc = ~irc;
	always #30 xt = xt_en ? ~xt : xt;
	always #100 rc = ~rc;
	always @(posedge pll) pc++;

	rwt_unit u_dut (.clk(clk), .srst(srst), .avs_req(req), .avs_rsp(rsp),
		.pll_output_clock(pll), .internal_ref_clock(irc), .crystal_clock(xt),
		.rc_clock(rc), .rst_pin_in(pin_in), .rst_pin_out(pin_out),
		.rst_pin_oe(pin_oe), .stop_mode(stop), .normal_mode(1'b1),
		.crystal_up_status(1'b1), .nvm_valid(nvm_v), .nvm_period(nvm_p),
		.nvm_window(nvm_w), .sys_reset(sys_rst), .crystal_run(xrun),
		.pll_run(prun), .tick_irq(irq));

	// ==========================================================
	// shared tasks
	task automatic chk(input logic [31:0] got, exp, input string m);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask

	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		req <= '{read: !w, write: w, address: a, writedata: d};
		// no cycle count assumed: only the watchdog process ends a stuck wait
		do begin
			@(posedge clk);
		end while (rsp.waitrequest !== 1'b0);
		q = rsp.readdata;
		req <= '0;
	endtask

	// s: 0 internal reset, 1 tick request, 2 pin drive
	task automatic wt(input int s, input logic lvl, input int lim);
		n = 0;
		while ((s == 2 ? pin_oe : s ? irq : sys_rst) !== lvl && n < lim) begin
			@(posedge clk);
			n++;
		end
		chk(n < lim, 1, "wait ran out");
	endtask

	task automatic seq(input int start);
		p0 = start;
		wt(2, 0, 8000);
		chk((pc - p0) inside {[510:515]}, 1, "pin low length");
		chk(pin_out, 0, "pin drive level");
		wt(0, 0, 4000);
		chk((pc - p0) inside {[766:771]}, 1, "internal reset length");
	endtask

	task automatic give_verdict();
		$display("errors %0d checks %0d", num_errors, n_checks);
		if (num_errors == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// ==========================================================
	// scenarios
	initial begin
		repeat (12) @(posedge clk);
		srst <= 0;
		seq(pc);
		bus(0, 5'h10, 0);
		chk(q, 0, "clock ctrl reset value");
		bus(0, 5'h18, 0);
		chk(q, 0, "unmapped read");
		bus(1, 5'h00, 32'h41);
		bus(0, 5'h00, 0);
		chk(q, 0, "masked control write");
		bus(1, 5'h00, 32'h01);
		bus(1, 5'h00, 32'h03);
		bus(0, 5'h00, 0);
		chk(q, 32'h01, "second control write");
		bus(1, 5'h10, 32'h30);
		bus(0, 5'h10, 0);
		chk(q, 0, "clock select locked");
		// service well inside the 512-cycle timeout, then let it run out
		repeat (4) begin
			repeat (200) @(posedge clk);
			bus(1, 5'h04, 32'h55);
			bus(1, 5'h04, 32'haa);
		end
		chk(sys_rst, 0, "serviced watchdog");
		wt(0, 1, 700);
		seq(pc);
		bus(0, 5'h14, 0);
		chk(q[0], 1, "watchdog cause");
		bus(1, 5'h00, 32'h07);
		bus(1, 5'h04, 32'h33);
		wt(0, 1, 6);
		seq(pc);
		bus(1, 5'h00, 32'h81);
		bus(1, 5'h04, 32'h55);
		wt(0, 1, 6);
		seq(pc);
		ext_rst <= 0;
		wt(0, 1, 10);
		repeat (7000) @(posedge clk);
		chk(sys_rst, 1, "held by pin");
		ext_rst <= 1;
		wt(0, 0, 10);
		bus(1, 5'h0c, 32'h02);
		bus(1, 5'h08, 32'h03);
		wt(1, 1, 60);
		bus(1, 5'h0c, 32'h06);
		repeat (2) @(posedge clk);
		chk(irq, 0, "tick flag cleared");
		wt(1, 1, 60);
		bus(1, 5'h10, 32'h01);
		repeat (2) @(posedge clk);
		chk({xrun, prun}, 2'b11, "run outside stop");
		stop <= 1;
		repeat (3) @(posedge clk);
		chk({xrun, prun}, 2'b00, "full stop");
		stop <= 0;
		bus(1, 5'h10, 32'h03);
		xt_en = 0;
		wt(0, 1, 400);
		xt_en = 1;
		seq(pc);
		// preload values are taken when the next sequence ends
		nvm_v <= 1;
		nvm_p <= 3'h2;
		nvm_w <= 1;
		pll_en = 0;
		wt(0, 1, 400);
		pll_en = 1;
		seq(pc);
		bus(0, 5'h00, 0);
		chk(q, 32'h82, "preloaded control");
		bus(1, 5'h00, 32'h00);
		bus(0, 5'h00, 0);
		chk(q, 32'h82, "off refused after preload");
		bus(0, 5'h14, 0);
		chk(q[4], 1, "refused write still counted");
		wt(0, 1, 3000);
		seq(pc);
		give_verdict();
	end

	// the scenarios need about 60k cycles
	initial begin
		#1000000;
		num_errors++;
		give_verdict();
	end
endmodule
`default_nettype wire
